/* verilog/page_pld_pkg.sv */
// page_pld_pkg: constants, offsets and carriers for the page register and
// the two programmable logic arrays that it feeds.
// assumes a single 100 MHz clock and a synchronous active-high reset.
package page_pld_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;            // clock_in period
    localparam int STBY_TIME_NS  = 70;            // quiet time before standby
    // least time, so round up to whole cycles
    localparam int STBY_CYC = (STBY_TIME_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // register offsets inside the configuration space
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_PAGE   = 8'hE0;    // memory_page_select
    localparam logic [7:0] OFF_PMGT0  = 8'hB0;    // power_mgmt_reg_zero
    localparam logic [7:0] OFF_PMGT2  = 8'hB4;    // power_mgmt_reg_two
    localparam logic [7:0] OFF_MC_AB  = 8'h20;    // output_cells_port_ab
    localparam logic [7:0] OFF_MC_BC  = 8'h21;    // output_cells_port_bc
    localparam logic [7:0] OFF_IN_A   = 8'h0A;    // input cells, port a
    localparam logic [7:0] OFF_IN_B   = 8'h0B;    // input cells, port b
    localparam logic [7:0] OFF_IN_C   = 8'h0C;    // input cells, port c

    // reset values
    localparam logic [7:0] PAGE_RST   = 8'h00;
    localparam logic [7:0] PMGT0_RST  = 8'h00;
    localparam logic [4:0] PMGT2_RST  = 5'h00;
    localparam logic [7:0] MC_RST     = 8'h00;

    // field positions
    localparam int FAST_BIT   = 3;                // fast mode in reg zero
    localparam int GATE_BITS  = 5;                // control gates in reg two

    // ----------------------------------------------------------------
    // array input bus layout (73 signals)
    // ----------------------------------------------------------------
    localparam int BUS_W    = 73;
    localparam int B_ADDR   = 0;                  // 16 address lines
    localparam int B_CNTL   = 16;                 // 3 bus controls
    localparam int B_RST    = 19;
    localparam int B_PDN    = 20;
    localparam int B_PORT   = 21;                 // 24 input cells
    localparam int B_PD     = 45;                 // 3 port d inputs
    localparam int B_PAGE   = 48;                 // 8 page bits
    localparam int B_FB_AB  = 56;                 // group ab feedback
    localparam int B_FB_BC  = 64;                 // group bc feedback
    localparam int B_BUSY   = 72;                 // programming busy

    // product term counts
    localparam int DEC_TERMS  = 42;               // decode array terms
    localparam int T_CFG      = 38;               // config select term
    localparam int GEN_TERMS  = 65;               // general array terms used
    localparam int GEN_MAX    = 137;              // ceiling of the and array

    // default config select: address[15:8] == FFh
    localparam logic [BUS_W-1:0] CFG_CARE = 73'h0_0000_0000_0000_0000_FF00;
    localparam logic [BUS_W-1:0] CFG_VAL  = 73'h0_0000_0000_0000_0000_FF00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [19:0] addr;                        // host address
        logic [7:0]  data;                        // host write data
        logic [2:0]  cntl;                        // bus_control_inputs
        logic        wr;                          // write strobe, high
        logic        rd;                          // read strobe, high
    } host_bus_s;

    typedef struct packed {
        logic [7:0] flash;                        // main flash sectors
        logic [3:0] boot;                         // boot memory sectors
        logic       sram;                         // static ram
        logic       cfg;                          // config_space_select
        logic       jtag;                         // test port enable
        logic [1:0] periph;                       // peripheral selects
    } decode_sel_s;

endpackage : page_pld_pkg

/* verilog/page_pld_core.sv */
// page_pld_core: memory page register, address decode array and general
// logic array with host load and readback of the macrocells.
// assumes host pins arrive asynchronously and are synchronised here, and
// that the array equations are fixed by parameters at build time.
//
// Contract
// - eight-bit page register, host written and read
// - page bits feed the address decode array
// - page bits also feed general logic array
// - page register sits at config base plus E0h
// - array equations active straight from reset
// - shared 73-signal input bus for both arrays
// - extended bus type uses address bits 19:4
// - fast off: standby after 70 ns quiet
// - fast mode is bit 3 of reg zero
// - three of the five reg two bits (0..2) gate bus controls
// - eight flash selects, three terms each
// - four boot selects, three terms each
// - sram select two terms, plus config select
// - test port select and two peripheral selects
// - three port d selects, no macrocell used
// - 24 input cells, 16 macrocells, 137 terms
// - host loads and reads macrocells directly
// - group ab to ports a/b, bc to b/c
// - unplaced macrocell goes to a reachable port
// - macrocell n on data bit n per group
`timescale 1ns/1ps

module page_pld_core #(
    parameter bit                              EXT_ADDR = 1'b0,
    parameter logic [41:0][72:0] DEC_CARE = '0,
    parameter logic [41:0][72:0] DEC_VAL  = '0,
    parameter logic [41:0]       DEC_EN   = 42'h040_0000_0000,
    parameter logic [64:0][72:0] GEN_CARE = '0,
    parameter logic [64:0][72:0] GEN_VAL  = '0,
    parameter logic [64:0]       GEN_EN   = '0,
    parameter logic [15:0]       MC_INV   = 16'h0000,
    parameter logic [7:0]        AB_TO_A  = 8'hFF,
    parameter logic [7:0]        BC_TO_C  = 8'hFF
) (
    input  wire logic                    clock_in,
    input  wire logic                    sys_rst_in,
    input  wire page_pld_pkg::host_bus_s host_in,
    input  wire logic                    power_down_input_in,
    input  wire logic                    prog_busy_in,
    input  wire logic [23:0]             port_cells_in,
    input  wire logic [2:0]              port_d_in,
    output logic [7:0]                   host_data_out,
    output logic                         host_data_oe_n_out,
    output page_pld_pkg::decode_sel_s    decode_sel_out,
    output logic [7:0]                   port_a_out,
    output logic [7:0]                   port_b_out,
    output logic [7:0]                   port_c_out,
    output logic [2:0]                   port_d_cs_out,
    output logic [7:0]                   page_bits_out,
    output logic                         standby_out
);
    import page_pld_pkg::*;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one product term: every cared bit matches its value
    function automatic logic pterm(input logic [72:0] bus,
                                   input logic [72:0] care,
                                   input logic [72:0] val,
                                   input logic        en);
        pterm = en && (((bus ^ val) & care) == 73'h0);
    endfunction : pterm

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int SYNC_W = $bits(host_bus_s) + 2 + 24 + 3;
    logic [SYNC_W-1:0] sync1_q;            // first stage, read by sync2 only
    logic [SYNC_W-1:0] sync2_q;            // safe copy of pins
    logic              wr_prev_q;          // last safe write strobe
    host_bus_s         hb;                 // synchronised host bus
    logic              pdn_s;              // synchronised power down
    logic              busy_s;             // synchronised busy flag
    logic [23:0]       cells_s;            // input cells, pass through
    logic [2:0]        pd_s;               // port d inputs

    // two flops on every pin except sys_rst_in before any logic looks at it
    always_ff @(posedge clock_in) begin
        sync1_q   <= {host_in, power_down_input_in, prog_busy_in,
                      port_cells_in, port_d_in};
        sync2_q   <= sync1_q;
        wr_prev_q <= hb.wr;
    end

    assign {hb, pdn_s, busy_s, cells_s, pd_s} = sync2_q;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0]  page_q;                   // memory_page_select
    logic [7:0]  pmgt0_q;                  // power_mgmt_reg_zero
    logic [4:0]  pmgt2_q;                  // power_mgmt_reg_two
    logic [7:0]  mc_ab_q;                  // output_cells_port_ab
    logic [7:0]  mc_bc_q;                  // output_cells_port_bc
    logic        cfg_q;                    // config select, registered
    logic [7:0]  off;                      // low address byte
    logic        wr_take;                  // one host write, this cycle
    logic        rd_take;                  // host read in config space
    logic        fast;                     // fast mode bit

    assign off     = hb.addr[7:0];
    // write is taken on the trailing edge of the strobe
    assign wr_take = wr_prev_q && !hb.wr && cfg_q;
    assign rd_take = hb.rd && cfg_q;
    assign fast    = pmgt0_q[FAST_BIT];

    // named write enables per register
    wire we_page  = wr_take && (off == OFF_PAGE);
    wire we_pmgt0 = wr_take && (off == OFF_PMGT0);
    wire we_pmgt2 = wr_take && (off == OFF_PMGT2);
    wire we_mc_ab = wr_take && (off == OFF_MC_AB);
    wire we_mc_bc = wr_take && (off == OFF_MC_BC);

    // page register: one flop per data line, clears to page zero
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            page_q <= PAGE_RST;
        end else if (we_page) begin
            page_q <= hb.data;
        end
    end

    // power management registers
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            pmgt0_q <= PMGT0_RST;
            pmgt2_q <= PMGT2_RST;
        end else begin
            if (we_pmgt0) begin
                pmgt0_q <= hb.data;
            end
            if (we_pmgt2) begin
                pmgt2_q <= hb.data[GATE_BITS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // shared array input bus
    // ----------------------------------------------------------------
    logic [72:0] bus;                      // one bus for both arrays
    logic [15:0] addr_in;                  // address lines seen by arrays
    logic [2:0]  cntl_in;                  // controls after gating

    // extended bus type shifts the window up by four bits
    assign addr_in = EXT_ADDR ? hb.addr[19:4] : hb.addr[15:0];
    // gate bits 0..2 block the three controls; bits 3..4 are kept
    // for control signals this bus type does not carry
    assign cntl_in = hb.cntl & ~pmgt2_q[2:0];

    assign bus = {busy_s, mc_bc_q, mc_ab_q, page_q, pd_s,
                  cells_s, pdn_s, sys_rst_in, cntl_in, addr_in};

    // ----------------------------------------------------------------
    // decode array
    // ----------------------------------------------------------------
    logic [41:0] dterm;                    // decode product terms
    decode_sel_s dec;                      // decoded selects

    // terms are parameters, so equations hold from the first cycle
    generate
        for (genvar i = 0; i < DEC_TERMS; i++) begin : g_dec
            assign dterm[i] = pterm(bus, DEC_CARE[i], DEC_VAL[i],
                                    DEC_EN[i]);
        end
        for (genvar s = 0; s < 8; s++) begin : g_flash
            assign dec.flash[s] = |dterm[3*s +: 3];
        end
        for (genvar s = 0; s < 4; s++) begin : g_boot
            assign dec.boot[s] = |dterm[24 + 3*s +: 3];
        end
    endgenerate

    assign dec.sram   = |dterm[37:36];
    assign dec.cfg    = dterm[T_CFG];
    assign dec.jtag   = dterm[39];
    assign dec.periph = dterm[41:40];

    // ----------------------------------------------------------------
    // general logic array
    // ----------------------------------------------------------------
    logic [64:0] gterm;                    // general product terms
    logic [7:0]  sum_ab;                   // group ab sums, 3 terms each
    logic [7:0]  sum_bc;                   // group bc sums, 4 terms each
    logic [2:0]  cs_d;                     // port d selects, 3 terms each

    generate
        for (genvar i = 0; i < GEN_TERMS; i++) begin : g_gen
            assign gterm[i] = pterm(bus, GEN_CARE[i], GEN_VAL[i],
                                    GEN_EN[i]);
        end
        for (genvar n = 0; n < 8; n++) begin : g_sum
            assign sum_ab[n] = (|gterm[3*n +: 3]) ^ MC_INV[n];
            assign sum_bc[n] = (|gterm[24 + 4*n +: 4]) ^ MC_INV[8+n];
        end
        for (genvar n = 0; n < 3; n++) begin : g_csd
            // own terms, so no macrocell is spent on these
            assign cs_d[n] = |gterm[56 + 3*n +: 3];
        end
    endgenerate

    // macrocell flops; a host load overrides the array
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            mc_ab_q <= MC_RST;
            mc_bc_q <= MC_RST;
        end else begin
            mc_ab_q <= we_mc_ab ? hb.data : sum_ab;
            mc_bc_q <= we_mc_bc ? hb.data : sum_bc;
        end
    end

    // ----------------------------------------------------------------
    // standby detection
    // ----------------------------------------------------------------
    logic [72:0] bus_prev_q;               // bus one cycle ago
    logic [3:0]  quiet_q;                  // cycles with no input change
    logic        stby_q;                   // arrays parked
    wire         bus_same = (bus == bus_prev_q);
    wire [3:0]   quiet_d  = !bus_same ? 4'h0 :
                            (quiet_q == 4'(STBY_CYC)) ? quiet_q :
                            4'(quiet_q + 4'h1);

    // counts quiet cycles; any change wakes the arrays at once
    always_ff @(posedge clock_in) begin
        bus_prev_q <= bus;
        if (sys_rst_in) begin
            quiet_q <= 4'h0;
            stby_q  <= 1'b0;
        end else begin
            quiet_q <= quiet_d;
            stby_q  <= !fast && (quiet_d == 4'(STBY_CYC));
        end
    end

    // ----------------------------------------------------------------
    // output stage
    // ----------------------------------------------------------------
    decode_sel_s dec_s1_q;                 // slow path first stage
    logic [2:0]  csd_s1_q;                 // slow path port d selects

    // fast off costs one extra cycle of delay; in standby the inputs are
    // quiet, so the outputs already hold and nothing needs freezing
    always_ff @(posedge clock_in) begin
        dec_s1_q <= dec;
        csd_s1_q <= cs_d;
        if (sys_rst_in) begin
            decode_sel_out <= '0;
            port_d_cs_out  <= 3'h0;
            cfg_q          <= 1'b0;
        end else begin
            decode_sel_out <= fast ? dec : dec_s1_q;
            port_d_cs_out  <= fast ? cs_d : csd_s1_q;
            cfg_q          <= dec.cfg;
        end
    end

    // port routing: each macrocell picks one of its two ports
    wire [7:0] pa_d = mc_ab_q & AB_TO_A;
    wire [7:0] pb_d = (mc_ab_q & ~AB_TO_A) | (mc_bc_q & ~BC_TO_C);
    wire [7:0] pc_d = mc_bc_q & BC_TO_C;

    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            port_a_out    <= 8'h00;
            port_b_out    <= 8'h00;
            port_c_out    <= 8'h00;
            page_bits_out <= PAGE_RST;
            standby_out   <= 1'b0;
        end else begin
            port_a_out    <= pa_d;
            port_b_out    <= pb_d;
            port_c_out    <= pc_d;
            page_bits_out <= page_q;
            standby_out   <= stby_q;
        end
    end

    // ----------------------------------------------------------------
    // host readback
    // ----------------------------------------------------------------
    logic [7:0] rd_data;                   // selected read value
    logic       rd_hit;                    // offset is mapped

    always_comb begin
        rd_hit  = 1'b1;
        case (off)
            OFF_PAGE:  rd_data = page_q;
            OFF_PMGT0: rd_data = pmgt0_q;
            OFF_PMGT2: rd_data = {3'h0, pmgt2_q};
            OFF_MC_AB: rd_data = mc_ab_q;
            OFF_MC_BC: rd_data = mc_bc_q;
            OFF_IN_A:  rd_data = cells_s[7:0];
            OFF_IN_B:  rd_data = cells_s[15:8];
            OFF_IN_C:  rd_data = cells_s[23:16];
            default: begin
                rd_data = 8'h00;
                rd_hit  = 1'b0;
            end
        endcase
    end

    // drive the data bus only for a mapped read in config space
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            host_data_out      <= 8'h00;
            host_data_oe_n_out <= 1'b1;
        end else begin
            host_data_out      <= rd_data;
            host_data_oe_n_out <= !(rd_take && rd_hit);
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);

    sequence s_quiet;
        (!fast && bus_same)[*8];
    endsequence

    a_page_reset: assert property (disable iff (1'b0)
        sys_rst_in |=> page_q == PAGE_RST)
        else $error("page not cleared by reset");
    a_page_write: assert property (
        we_page |=> page_q == $past(hb.data) &&
                    bus[55:48] == $past(hb.data))
        else $error("page write not visible next cycle");
    a_page_hold: assert property (
        !we_page |=> $stable(page_q))
        else $error("page changed without a write");
    a_page_read: assert property (
        rd_take && off == OFF_PAGE |=> !host_data_oe_n_out &&
                    host_data_out == $past(page_q))
        else $error("page readback wrong");
    a_addr_window: assert property (
        bus[B_ADDR +: 16] == (EXT_ADDR ? hb.addr[19:4] : hb.addr[15:0]))
        else $error("address window wrong");
    a_cntl_gate: assert property (
        |pmgt2_q[2:0] |-> (bus[B_CNTL +: 3] & pmgt2_q[2:0]) == 3'h0)
        else $error("gated control reached arrays");
    a_stby_enter: assert property (
        s_quiet |-> ##[0:2] stby_q)
        else $error("no standby after quiet inputs");
    a_stby_exit: assert property (
        !bus_same |=> !stby_q)
        else $error("standby held across input change");
    a_fast_awake: assert property (
        fast |=> !stby_q)
        else $error("standby while fast mode set");
    a_mc_load: assert property (
        we_mc_bc |=> mc_bc_q == $past(hb.data))
        else $error("macrocell load lost");

endmodule : page_pld_core

/* test/host_model.sv */
// host_model: host bus master for the page register and array block.
// assumes a free clock; pins change only after the falling edge.
`timescale 1ns/1ps
module host_model
    import page_pld_pkg::*;
(
    input  wire logic       clock_in,
    input  wire logic [7:0] host_data_in,
    input  wire logic       host_data_oe_n_in,
    output host_bus_s       host_out
);
    initial host_out = '0;
    // wait n falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clock_in);
    endtask : cyc
    // released lines show the inverse, never the last value
    task automatic release_bus();
        cyc(5);
        host_out.addr = ~host_out.addr;
        host_out.data = ~host_out.data;
        // let an edge pass so the next request never lands in this step
        cyc(1);
    endtask : release_bus
    // bus controls are plain levels seen only by the arrays
    task automatic set_cntl(input logic [2:0] c);
        host_out.cntl = c;
    endtask : set_cntl
    // write: address settles before the strobe and holds after it
    task automatic write(input logic [11:0] base, input logic [7:0] off,
                         input logic [7:0] d);
        host_out.addr = {base, off};
        host_out.data = d;
        cyc(5);
        host_out.wr = 1'b1;
        cyc(4);
        host_out.wr = 1'b0;
        release_bus();
    endtask : write
    // read: bounded wait for the drive enable, data taken while it stands
    task automatic read(input logic [7:0] off, output logic [7:0] d,
                        output logic ok);
        host_out.addr = {12'h0FF, off};
        ok = 1'b0;
        d = 8'h00;
        cyc(5);
        host_out.rd = 1'b1;
        for (int i = 0; i < 10 && !ok; i++) begin
            cyc(1);
            ok = (host_data_oe_n_in === 1'b0);
        end
        if (ok) d = host_data_in;
        host_out.rd = 1'b0;
        release_bus();
    endtask : read
endmodule : host_model

/* test/test_page_pld_core.sv */
// test_page_pld_core: self-checking bench for page_pld_core.
// assumes the host model above; one flash and one macrocell term use page.
`timescale 1ns/1ps
module test_page_pld_core;
    import page_pld_pkg::*;
    localparam logic [72:0] PG = 73'h0FF << B_PAGE; // page bits cared
    localparam logic [72:0] PV = 73'h05A << B_PAGE; // page 5Ah matches
    logic        clock_in = 1'b0;
    logic        sys_rst_in = 1'b1;
    logic [23:0] cells = 24'hC3_96_3C;              // input cell levels
    logic        power_down_input = 1'b0;                        // power down pin
    logic        busy = 1'b0;                       // programming busy pin
    logic [2:0]  pd = 3'h0;                         // port d inputs
    host_bus_s   host_in;
    decode_sel_s sel;
    logic [7:0]  dout, pa, pb, pc, pg, d;
    logic [2:0]  pdcs;
    logic        oe_n, stby, ok;
    int          errors = 0;
    int          checked = 0;
    initial forever #5 clock_in = ~clock_in;
    page_pld_core #(.DEC_CARE('{38: CFG_CARE, 0: PG, default: 73'h0}),
        .DEC_VAL('{38: CFG_VAL, 0: PV, default: 73'h0}),
        .DEC_EN(42'h040_0000_0001), .GEN_CARE('{0: PG, default: 73'h0}),
        .GEN_VAL('{0: PV, default: 73'h0}), .GEN_EN(65'h1)) dut (
        .clock_in(clock_in), .sys_rst_in(sys_rst_in), .host_in(host_in),
        .power_down_input_in(power_down_input), .prog_busy_in(busy),
        .port_cells_in(cells), .port_d_in(pd), .host_data_out(dout),
        .host_data_oe_n_out(oe_n), .decode_sel_out(sel), .port_a_out(pa),
        .port_b_out(pb), .port_c_out(pc), .port_d_cs_out(pdcs),
        .page_bits_out(pg), .standby_out(stby));
    host_model host (.clock_in(clock_in), .host_data_in(dout),
        .host_data_oe_n_in(oe_n), .host_out(host_in));
    // one compare for every byte or flag result
    task automatic chk(input string name, input logic [7:0] exp, got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    // read that must be answered
    task automatic rd(input logic [7:0] off);
        host.read(off, d, ok);
        chk("read answered", 8'h01, {7'h0, ok});
    endtask : rd
    // reset values at the ports and in the register
    task automatic t_reset();
        chk("page after reset", PAGE_RST, pg);
        chk("oe_n idle", 8'h01, {7'h0, oe_n});
        rd(OFF_PAGE);
        chk("page read reset", PAGE_RST, d);
    endtask : t_reset
    // page write, readback and use in both arrays
    task automatic t_page();
        host.write(12'h0FF, OFF_PAGE, 8'h5A);
        chk("page bits", 8'h5A, pg);
        rd(OFF_PAGE);
        chk("page read", 8'h5A, d);
        chk("flash0 on page", 8'h01, {7'h0, sel.flash[0]});
        chk("cell ab0 on a", 8'h01, pa);
        chk("port b idle", 8'h00, pb);
        chk("port c idle", 8'h00, pc);
        chk("port d cs idle", 8'h00, {5'h0, pdcs});
        host.write(12'h0FF, OFF_PAGE, 8'hA5);
        chk("flash0 off page", 8'h00, {7'h0, sel.flash[0]});
        chk("cell ab0 off", 8'h00, pa);
    endtask : t_page
    // wrong base and unmapped offset are ignored
    task automatic t_refuse();
        host.write(12'h000, OFF_PAGE, 8'h11);
        chk("page wrong base", 8'hA5, pg);
        host.write(12'h0FF, OFF_MC_BC, 8'h3C);
        chk("page on cell load", 8'hA5, pg);
        host.read(8'h55, d, ok);
        chk("unmapped oe", 8'h00, {7'h0, ok});
        rd(OFF_IN_B);
        chk("input cells b", cells[15:8], d);
    endtask : t_refuse
    // standby with fast mode off, wake on inputs, gated controls stay
    // out of the arrays, none with fast mode on
    task automatic t_power();
        host.cyc(12);
        chk("standby quiet", 8'h01, {7'h0, stby});
        power_down_input = 1'b1;
        busy = 1'b1;
        pd = 3'h5;
        host.cyc(5);
        chk("standby wake", 8'h00, {7'h0, stby});
        host.write(12'h0FF, OFF_PMGT2, 8'h1F);
        rd(OFF_PMGT2);
        chk("gate bits", 8'h1F, d);
        host.cyc(12);
        chk("standby again", 8'h01, {7'h0, stby});
        host.set_cntl(3'h7);
        host.cyc(5);
        chk("gated controls quiet", 8'h01, {7'h0, stby});
        host.write(12'h0FF, OFF_PMGT0, 8'h08);
        host.cyc(12);
        chk("fast no standby", 8'h00, {7'h0, stby});
    endtask : t_power
    // reset in mid-run brings the page and gates back to zero
    task automatic t_rerst();
        sys_rst_in = 1'b1;
        host.cyc(5);
        sys_rst_in = 1'b0;
        host.cyc(3);
        chk("page after second reset", PAGE_RST, pg);
        rd(OFF_PAGE);
        chk("page read second reset", PAGE_RST, d);
        rd(OFF_PMGT2);
        chk("gates after reset", {3'h0, PMGT2_RST}, d);
    endtask : t_rerst
    task automatic give_verdict();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(negedge clock_in);
        sys_rst_in = 1'b0;
        host.cyc(3);
        t_reset();
        t_page();
        t_refuse();
        t_power();
        t_rerst();
        give_verdict();
    end
endmodule : test_page_pld_core
